// File: ftb_pkg.sv
package ftb_pkg;
    // register offsets on the host register port
    localparam logic [7:0] FTB_OFS_THRESH = 8'h06;
    localparam logic [7:0] FTB_OFS_IDENT = 8'h08;
    localparam logic [7:0] FTB_OFS_ADDR = 8'h09;
    // widths
    localparam int FTB_DATA_W = 16;
    localparam int FTB_THR_W = 6;
    localparam int FTB_CNT_W = 7;
    localparam int FTB_TADDR_W = 7;
    // field positions
    localparam int FTB_THR_LSB = 8;
    localparam int FTB_THR_MSB = 13;
    localparam int FTB_TADDR_LSB = 1;
    localparam int FTB_TADDR_MSB = 7;
    localparam int FTB_UNLOCK_LSB = 8;
    localparam int FTB_UNLOCK_MSB = 15;
    // reset values
    localparam logic [5:0] FTB_THR_RST = 6'h00;
    localparam logic [6:0] FTB_TADDR_RST = 7'h64;
    localparam logic [15:0] FTB_RDATA_RST = 16'h0000;
    // identification values, arbitrary
    localparam logic [7:0] FTB_REV_CODE = 8'h01;
    localparam logic [7:0] FTB_PART_CODE = 8'h5A;
    // unlock byte written alongside a new target address
    localparam logic [7:0] FTB_UNLOCK_KEY = 8'hAD;
    // enabling codes of the address change key register
    localparam logic [15:0] FTB_KEY_ALWAYS = 16'h04AD;
    localparam logic [15:0] FTB_KEY_GPIO0 = 16'h44AD;
    localparam logic [15:0] FTB_KEY_GPIO1 = 16'h84AD;
    localparam logic [15:0] FTB_KEY_BOTH = 16'hC4AD;
endpackage : ftb_pkg

// File: ftb_fifo_irq.sv
`timescale 1ns/100ps
module ftb_fifo_irq
    import ftb_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rstn, // sync reset, active low
    input wire logic [FTB_CNT_W-1:0] fifo_word_count, // words held in the fifo
    input wire logic [FTB_THR_W-1:0] threshold, // programmed level threshold
    input wire logic fifo_irq_mask, // 1 blocks the interrupt
    output logic fifo_irq // level interrupt, registered
);
    logic fifo_irq_ff; // interrupt level flop
    logic nxt_fifo_irq; // next interrupt level
    logic above; // count strictly above threshold

    // compare every cycle, level follows the result with no latching
    always_comb begin
        above = (fifo_word_count > {1'b0, threshold});
        nxt_fifo_irq = above && !fifo_irq_mask;
    end

    // register the level
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            fifo_irq_ff <= 1'b0;
        end else begin
            fifo_irq_ff <= nxt_fifo_irq;
        end
    end

    assign fifo_irq = fifo_irq_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_irq_raise;
        (fifo_word_count > {1'b0, threshold}) && !fifo_irq_mask |=> fifo_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("fifo irq not raised above threshold");

    property p_irq_drop;
        fifo_irq && (fifo_word_count <= {1'b0, threshold}) |=> !fifo_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("fifo irq not dropped at or below threshold");

    property p_irq_mask;
        fifo_irq_mask |=> !fifo_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("fifo irq passed while masked");

    property p_irq_follow;
        $changed(fifo_word_count) || $changed(threshold) |=>
            fifo_irq == $past((fifo_word_count > {1'b0, threshold}) && !fifo_irq_mask);
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("fifo irq does not follow comparison");
endmodule : ftb_fifo_irq

// File: ftb_regs.sv
`timescale 1ns/100ps
module ftb_regs
    import ftb_pkg::*;
(
    input wire logic sys_clk, // system clock, 50 MHz
    input wire logic rstn, // sync reset, active low
    input wire logic [7:0] reg_addr, // register address from serial port
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic [FTB_DATA_W-1:0] reg_wdata, // write data
    output logic [FTB_DATA_W-1:0] reg_rdata, // read data, registered
    output logic reg_rvalid, // read data valid pulse
    input wire logic [FTB_CNT_W-1:0] fifo_word_count, // fifo fill level
    input wire logic fifo_irq_mask, // mask bit from interrupt mask register
    input wire logic [15:0] address_change_key, // key register contents
    input wire logic gpio0_level, // gpio0 pin level
    input wire logic gpio1_level, // gpio1 pin level
    output logic fifo_irq, // fifo threshold interrupt level
    output logic [FTB_TADDR_W-1:0] bus_target_address // two-wire target address
);
    logic [FTB_THR_W-1:0] thr_ff; // fifo_level_threshold
    logic [FTB_THR_W-1:0] nxt_thr;
    logic [FTB_TADDR_W-1:0] taddr_ff; // bus target address
    logic [FTB_TADDR_W-1:0] nxt_taddr;
    logic [FTB_DATA_W-1:0] rdata_ff; // read data
    logic [FTB_DATA_W-1:0] nxt_rdata;
    logic rvalid_ff; // read valid
    logic nxt_rvalid;
    logic key_open; // address change allowed by key and pins
    logic unlock_ok; // unlock byte present in the write

    // key decode for keyed address change
    always_comb begin
        case (address_change_key)
            FTB_KEY_ALWAYS: key_open = 1'b1;
            FTB_KEY_GPIO0: key_open = gpio0_level;
            FTB_KEY_GPIO1: key_open = gpio1_level;
            FTB_KEY_BOTH: key_open = gpio0_level && gpio1_level;
            default: key_open = 1'b0; // locked
        endcase
        unlock_ok = (reg_wdata[FTB_UNLOCK_MSB:FTB_UNLOCK_LSB] == FTB_UNLOCK_KEY);
    end

    // next values of the writable fields
    always_comb begin
        nxt_thr = thr_ff;
        nxt_taddr = taddr_ff;
        if (reg_wr && reg_addr == FTB_OFS_THRESH) begin
            nxt_thr = reg_wdata[FTB_THR_MSB:FTB_THR_LSB]; // reserved bits dropped
        end
        if (reg_wr && reg_addr == FTB_OFS_ADDR && unlock_ok && key_open) begin
            nxt_taddr = reg_wdata[FTB_TADDR_MSB:FTB_TADDR_LSB];
        end
    end

    // field registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            thr_ff <= FTB_THR_RST;
            taddr_ff <= FTB_TADDR_RST;
        end else begin
            thr_ff <= nxt_thr;
            taddr_ff <= nxt_taddr;
        end
    end

    // read mux, unmapped and write-only bits read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_rvalid = reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                FTB_OFS_THRESH: nxt_rdata = {2'h0, thr_ff, 8'h00};
                FTB_OFS_IDENT: nxt_rdata = {FTB_REV_CODE, FTB_PART_CODE};
                FTB_OFS_ADDR: nxt_rdata = {8'h00, taddr_ff, 1'b0}; // unlock byte reads zero
                default: nxt_rdata = FTB_RDATA_RST; // unmapped
            endcase
        end
    end

    // read port registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdata_ff <= FTB_RDATA_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign bus_target_address = taddr_ff;

    // threshold compare and interrupt level
    ftb_fifo_irq u_fifo_irq (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .fifo_word_count(fifo_word_count),
        .threshold(thr_ff),
        .fifo_irq_mask(fifo_irq_mask),
        .fifo_irq(fifo_irq)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_thr_write;
        reg_wr && reg_addr == FTB_OFS_THRESH;
    endsequence

    sequence s_thr_readback;
        reg_rd && reg_addr == FTB_OFS_THRESH ##1 reg_rvalid;
    endsequence

    property p_thr_write;
        s_thr_write |=> thr_ff == $past(reg_wdata[FTB_THR_MSB:FTB_THR_LSB]);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write not stored");

    property p_thr_read;
        s_thr_readback |-> reg_rdata[FTB_THR_MSB:FTB_THR_LSB] == $past(thr_ff)
            && reg_rdata[7:0] == 8'h00 && reg_rdata[15:14] == 2'h0;
    endproperty
    a_thr_read: assert property (p_thr_read) else $error("threshold readback wrong");

    sequence s_keyed_write;
        reg_wr && reg_addr == FTB_OFS_ADDR && unlock_ok && address_change_key == FTB_KEY_ALWAYS;
    endsequence

    property p_addr_keyed;
        s_keyed_write |=> bus_target_address == $past(reg_wdata[FTB_TADDR_MSB:FTB_TADDR_LSB]);
    endproperty
    a_addr_keyed: assert property (p_addr_keyed) else $error("keyed address write not taken");

    property p_addr_locked;
        reg_wr && reg_addr == FTB_OFS_ADDR && (!unlock_ok || !key_open) |=> $stable(bus_target_address);
    endproperty
    a_addr_locked: assert property (p_addr_locked) else $error("address changed without unlock");

    property p_addr_gpio;
        reg_wr && reg_addr == FTB_OFS_ADDR && address_change_key == FTB_KEY_GPIO0 && !gpio0_level
            |=> $stable(bus_target_address);
    endproperty
    a_addr_gpio: assert property (p_addr_gpio) else $error("address changed with gpio0 low");

    property p_addr_read;
        reg_rd && reg_addr == FTB_OFS_ADDR |=> reg_rvalid && reg_rdata[0] == 1'b0
            && reg_rdata[15:8] == 8'h00 && reg_rdata[7:1] == $past(taddr_ff);
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("address readback wrong");

    // no read strobe, no valid pulse one cycle later
    property p_rvalid_idle;
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid_idle: assert property (p_rvalid_idle) else $error("read valid without read strobe");

    // read data holds between reads
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

    // threshold moves only on a write to its own register
    property p_thr_idle;
        !(reg_wr && reg_addr == FTB_OFS_THRESH) |=> $stable(thr_ff);
    endproperty
    a_thr_idle: assert property (p_thr_idle) else $error("threshold moved without its write");

    // target address moves only on a write to its own register
    property p_addr_idle;
        !(reg_wr && reg_addr == FTB_OFS_ADDR) |=> $stable(bus_target_address);
    endproperty
    a_addr_idle: assert property (p_addr_idle) else $error("address moved without its write");

    // gpio0 key with gpio0 high lets the keyed write through
    property p_g0_open;
        reg_wr && reg_addr == FTB_OFS_ADDR && unlock_ok && address_change_key == FTB_KEY_GPIO0 && gpio0_level
            |=> bus_target_address == $past(reg_wdata[FTB_TADDR_MSB:FTB_TADDR_LSB]);
    endproperty
    a_g0_open: assert property (p_g0_open) else $error("gpio0 keyed write not taken");

    // gpio1 key with gpio1 low keeps the address
    property p_g1_shut;
        reg_wr && reg_addr == FTB_OFS_ADDR && address_change_key == FTB_KEY_GPIO1 && !gpio1_level
            |=> $stable(bus_target_address);
    endproperty
    a_g1_shut: assert property (p_g1_shut) else $error("gpio1 key took write, pin low");

    // gpio1 key with gpio1 high lets the keyed write through
    property p_g1_open;
        reg_wr && reg_addr == FTB_OFS_ADDR && unlock_ok && address_change_key == FTB_KEY_GPIO1 && gpio1_level
            |=> bus_target_address == $past(reg_wdata[FTB_TADDR_MSB:FTB_TADDR_LSB]);
    endproperty
    a_g1_open: assert property (p_g1_open) else $error("gpio1 keyed write not taken");

    // both-pin key with both pins high lets the keyed write through
    property p_both_open;
        reg_wr && reg_addr == FTB_OFS_ADDR && unlock_ok && address_change_key == FTB_KEY_BOTH
            && gpio0_level && gpio1_level |=> bus_target_address == $past(reg_wdata[FTB_TADDR_MSB:FTB_TADDR_LSB]);
    endproperty
    a_both_open: assert property (p_both_open) else $error("both-pin keyed write not taken");

    // both-pin key with either pin low keeps the address
    property p_both_shut;
        reg_wr && reg_addr == FTB_OFS_ADDR && address_change_key == FTB_KEY_BOTH
            && !(gpio0_level && gpio1_level) |=> $stable(bus_target_address);
    endproperty
    a_both_shut: assert property (p_both_shut) else $error("both-pin key took write, pin low");

    // a raised interrupt always has an unmasked count above threshold behind it
    property p_irq_cause;
        fifo_irq |-> $past(fifo_word_count > {1'b0, thr_ff}) && !$past(fifo_irq_mask);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("fifo irq without cause");

    // sync reset loads the field reset values, checked one cycle after reset is sampled low
    property p_reset_vals;
        disable iff (1'b0) !rstn |=> thr_ff == FTB_THR_RST && taddr_ff == FTB_TADDR_RST
            && !reg_rvalid && !fifo_irq;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values not loaded");
endmodule : ftb_regs

// File: ftb_host.sv
`timescale 1ns/100ps
module ftb_host
    import ftb_pkg::*;
(
    output logic [7:0] reg_addr, // register address
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic [15:0] reg_wdata, // write data
    input wire logic sys_clk, // system clock
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_rvalid // read valid pulse
);
    // idle port at time zero
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end
    // one write, data and strobe held for one clock cycle
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge sys_clk) #1;
        reg_wr = 1'b0;
        reg_wdata = ~v; // stale data not left on the lines
    endtask : wr
    // one read, data taken with the valid pulse
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk) #1;
        v = reg_rvalid ? reg_rdata : 16'hDEAD; // missing pulse gives a bad value
        reg_rd = 1'b0;
    endtask : rd
endmodule : ftb_host

// File: ftb_regs_tb_top.sv
`timescale 1ns/100ps
module ftb_regs_tb_top
    import ftb_pkg::*;
;
    logic sys_clk, rstn, reg_wr, reg_rd, reg_rvalid, fifo_irq_mask, gpio0_level, gpio1_level, fifo_irq;
    logic [7:0] reg_addr; // host address
    logic [15:0] reg_wdata, reg_rdata, address_change_key, d; // data and key
    logic [6:0] fifo_word_count, bus_target_address, exp_a; // level and addresses
    int failures, n_compared, cycles;
    ftb_regs DUT (.sys_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .fifo_word_count, .fifo_irq_mask, .address_change_key, .gpio0_level, .gpio1_level, .fifo_irq,
        .bus_target_address);
    ftb_host h (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
    // verdict and end of run
    task automatic summarize;
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // compare and count
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // set level and mask, check irq one edge later
    task automatic irq(input logic [6:0] c, input logic m, input logic e);
        fifo_word_count = c;
        fifo_irq_mask = m;
        @(posedge sys_clk) #1;
        chk({15'h0000, fifo_irq}, {15'h0000, e});
    endtask : irq
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 2000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        {rstn, fifo_irq_mask, gpio0_level, gpio1_level} = 4'h4;
        fifo_word_count = 7'h00;
        address_change_key = 16'h0000;
        repeat (4) @(posedge sys_clk);
        #1 rstn = 1'b1;
        chk({9'h000, bus_target_address}, 16'h0064);
        h.rd(FTB_OFS_THRESH, d);
        chk(d, 16'h0000);
        h.rd(FTB_OFS_ADDR, d);
        chk(d, 16'h00C8);
        h.wr(FTB_OFS_IDENT, 16'h0000);
        h.rd(FTB_OFS_IDENT, d);
        chk(d, {FTB_REV_CODE, FTB_PART_CODE});
        h.rd(8'h07, d);
        chk(d, 16'h0000);
        h.wr(FTB_OFS_THRESH, 16'hFFFF);
        h.rd(FTB_OFS_THRESH, d);
        chk(d, 16'h3F00);
        irq(7'h3F, 1'b0, 1'b0);
        irq(7'h40, 1'b0, 1'b1);
        h.wr(FTB_OFS_THRESH, 16'h0400);
        irq(7'h05, 1'b0, 1'b1);
        irq(7'h04, 1'b0, 1'b0);
        irq(7'h05, 1'b1, 1'b0);
        irq(7'h05, 1'b0, 1'b1);
        // wrong unlock byte, then every key code against every pin level
        exp_a = 7'h64;
        address_change_key = FTB_KEY_ALWAYS;
        h.wr(FTB_OFS_ADDR, 16'h1254);
        chk({9'h000, bus_target_address}, {9'h000, exp_a});
        for (int k = 0; k < 4; k++) begin
            for (int g = 0; g < 4; g++) begin
                address_change_key = {k[1:0], FTB_KEY_ALWAYS[13:0]};
                {gpio1_level, gpio0_level} = g[1:0];
                h.wr(FTB_OFS_ADDR, {FTB_UNLOCK_KEY, 1'b1, k[1:0], g[1:0], 3'h4});
                if ((k[1:0] & ~g[1:0]) == 2'b00) exp_a = {1'b1, k[1:0], g[1:0], 2'b10};
                h.rd(FTB_OFS_ADDR, d);
                chk(d, {8'h00, exp_a, 1'b0});
            end
        end
        // mid-run reset puts the fields back to their reset values
        rstn = 1'b0;
        @(posedge sys_clk) #1;
        rstn = 1'b1;
        exp_a = 7'h64;
        chk({9'h000, bus_target_address}, {9'h000, exp_a});
        irq(7'h01, 1'b0, 1'b1); // threshold back to zero
        h.rd(FTB_OFS_THRESH, d);
        chk(d, 16'h0000);
        address_change_key = 16'h0000;
        h.wr(FTB_OFS_ADDR, 16'hAD02);
        chk({9'h000, bus_target_address}, {9'h000, exp_a});
        summarize();
    end
endmodule : ftb_regs_tb_top
